// ===== test/bdsc_host_pod.sv
// Host pod model that drives the open-drain serial pin.
module bdsc_host_pod (
  // Clock
  input  wire logic sys_clk,
  // Pin pull-down request
  output logic      drive_low
);
  timeunit 1ns;
  timeprecision 1ps;
  initial drive_low = 1'b0;
  // Each transfer opens with a fall, then the pin returns to its pull-up.
  task automatic send_low(input int len);
    @(negedge sys_clk) drive_low = 1'b1;
    repeat (len) @(negedge sys_clk);
    drive_low = 1'b0;
  endtask
  // During tagging the pin carries the high tag, low meaning tag.
  task automatic hold_tag(input logic hi);
    drive_low = ~hi;
  endtask
endmodule

// ===== test/tb_bdsc_top.sv
// Self-checking bench for the background debug serial control block.
module tb_bdsc_top;
  timeunit 1ns;
  timeprecision 1ps;
  import bdsc_pkg::*;
  localparam int TO = 200;
  logic sys_clk, rst, low_strobe_in, low_strobe_enabled, ext_clk;
  logic irq_pending, host_low;
  logic [11:0] p;
  logic serial_out, serial_oe_n, soft_reset, bit_valid, sync_seen;
  logic ack_enabled, tagging_active, background_debug_mode;
  logic run_user, take_irq_stack;
  logic [1:0] tag_seen, e;
  int fail_count, compares, n, s, n_sr, n_bv, n_sy;
  // The pin has a pull-up, so a released line reads high.
  wire pin = host_low ? 1'b0 : (serial_oe_n ? 1'b1 : serial_out);

  bdsc_host_pod host_u (.sys_clk, .drive_low(host_low));
  bdsc_top #(.TIMEOUT(TO)) dut_u (
    .sys_clk, .rst, .serial_in(pin), .serial_out, .serial_oe_n,
    .low_strobe_in, .low_strobe_enabled, .external_bus_clock(ext_clk),
    .cmd_complete(p[0]), .cmd_is_read(p[1]), .xfer_done(p[2]),
    .ack_enable_cmd(p[3]), .ack_disable_cmd(p[4]), .ack_pulse_sent(p[5]),
    .single_step_command(p[6]), .tag_and_go_command(p[7]),
    .clocks_restarted(p[8]), .irq_pending, .insn_retired(p[11]),
    .queue_load(p[9]), .queue_advance(p[10]), .soft_reset, .bit_valid,
    .sync_seen, .ack_enabled, .tagging_active, .background_debug_mode,
    .run_user, .take_irq_stack, .tag_seen
  );

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  always @(negedge sys_clk) begin
    n_sr += int'(soft_reset === 1'b1);
    n_bv += int'(bit_valid === 1'b1);
    n_sy += int'(sync_seen === 1'b1);
  end

  task automatic chk(input logic ok, input string m);
    compares++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask

  function automatic logic sig(input int k);
    case (k)
      0: return soft_reset;
      1: return bit_valid;
      2: return run_user;
      3: return background_debug_mode;
      4: return take_irq_stack;
      default: return ~serial_oe_n & ~serial_out;
    endcase
  endfunction

  task automatic waitk(input int k, input int lim, input bit must);
    n = 0;
    while (sig(k) !== 1'b1 && n < lim) begin
      @(negedge sys_clk);
      n++;
    end
    if (must && n == lim) begin
      $display("CHECK FAILED %0t wait %0d timed out", $time, k);
      fail_count++;
      give_verdict();
    end
  endtask

  task automatic pulse(input logic [11:0] m);
    @(negedge sys_clk) p = m;
    @(negedge sys_clk) p = 12'h000;
  endtask

  task automatic do_reset();
    rst = 1'b1;
    repeat (12) @(negedge sys_clk);
    rst = 1'b0;
    repeat (4) @(negedge sys_clk);
  endtask

  task automatic bit10();
    host_u.send_low(10);
    waitk(1, 12, 1);
  endtask

  task automatic give_verdict();
    $display("fail_count=%0d compares=%0d", fail_count, compares);
    if (fail_count == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    {rst, low_strobe_in, low_strobe_enabled, ext_clk, irq_pending} = 5'h1a;
    p = 12'h000;
    void'($urandom(32'ha228));
    do_reset();
    chk(ack_enabled === 1'b0 && serial_oe_n === 1'b1, "reset");
    // Random short lows, ending just under the sync length.
    for (int i = 0; i < 4; i++) begin
      host_u.send_low(i == 3 ? 120 : 5 + int'($urandom % 90));
      waitk(1, 12, 1);
      repeat (10) @(negedge sys_clk);
    end
    chk(n_sy == 0 && n_sr == 0 && n_bv == 4, "bits");
    host_u.send_low(10);
    waitk(0, TO + 20, 1);
    chk(n + 10 >= TO && n + 10 <= TO + 8, "timeout");
    bit10();
    pulse(12'h001);
    s = n_sr;
    repeat (2 * TO) @(negedge sys_clk);
    chk(n_sr == s, "idle");
    s = n_sy;
    host_u.send_low(300);
    chk(n_sy == s + 1, "sync");
    waitk(5, 40, 1);
    chk(n >= SYNC_DELAY_CYC && n <= SYNC_DELAY_CYC + 8, "delay");
    n = 0;
    while (sig(5) === 1'b1 && n < 300) begin
      @(negedge sys_clk);
      n++;
    end
    chk(n == SYNC_RESP_CYC && serial_out === 1'b1, "low");
    @(negedge sys_clk);
    chk(serial_oe_n === 1'b1, "release");
    repeat (10) @(negedge sys_clk);
    pulse(12'h008);
    chk(ack_enabled === 1'b1, "ack on");
    bit10();
    pulse(12'h003);
    s = n_sr;
    repeat (3 * TO) @(negedge sys_clk);
    chk(n_sr == s, "held");
    pulse(12'h020);
    waitk(0, TO + 20, 1);
    chk(n >= TO - 4 && n <= TO + 8, "rearm");
    pulse(12'h010);
    bit10();
    pulse(12'h003);
    waitk(0, TO + 20, 1);
    chk(ack_enabled === 1'b0 && n <= TO, "expire");
    pulse(12'h008);
    bit10();
    pulse(12'h100);
    waitk(0, 6, 1);
    chk(ack_enabled === 1'b0, "restart");
    // Every tag pin code, last one tags the high byte so the core stops.
    for (int i = 3; i >= 0; i--) begin
      do_reset();
      pulse(12'h080);
      low_strobe_enabled = 1'($urandom);
      chk(tagging_active === 1'b1, "tag on");
      host_u.hold_tag(i[1]);
      low_strobe_in = i[0];
      ext_clk = 1'b1;
      repeat (6) @(negedge sys_clk);
      ext_clk = 1'b0;
      repeat (8) @(negedge sys_clk);
      e = {~i[1], ~i[0] & low_strobe_enabled};
      chk(tag_seen === e, "tag");
      pulse(12'h200);
      pulse(12'h400);
      pulse(12'h400);
      waitk(3, 10, 0);
      chk((n < 10) == (e != 2'h0), "head");
      chk(tagging_active === (e == 2'h0), "tag off");
      host_u.hold_tag(1'b1);
      low_strobe_in = 1'b1;
      ext_clk = 1'b1;
    end
    pulse(12'h040);
    waitk(2, 10, 1);
    pulse(12'h800);
    waitk(3, 10, 1);
    chk(run_user === 1'b0, "one step");
    irq_pending = 1'b1;
    pulse(12'h040);
    waitk(4, 10, 1);
    s = 0;
    repeat (10) begin
      @(negedge sys_clk);
      s += int'(run_user === 1'b1);
    end
    chk(s == 0 && background_debug_mode === 1'b1, "irq step");
    give_verdict();
  end
endmodule

// ===== verilog/bdsc_pkg.sv
// Shared constants and types for the background debug serial control block.
package bdsc_pkg;
  localparam int SYNC_LOW_CYC   = 128;
  localparam int TIMEOUT_CYC    = 512;
  localparam int SYNC_DELAY_CYC = 16;
  localparam int SYNC_RESP_CYC  = 128;
  localparam int CNT_W          = 10;
  localparam int QUEUE_DEPTH    = 2;

  typedef enum logic [1:0] {
    BDSC_IDLE,
    BDSC_LOW,
    BDSC_WAIT_HI,
    BDSC_GAP
  } bdsc_rx_t;

  typedef enum logic [1:0] {
    BDSC_RSP_IDLE,
    BDSC_RSP_DELAY,
    BDSC_RSP_LOW,
    BDSC_RSP_SPEED
  } bdsc_rsp_t;

  typedef enum logic [1:0] {
    BDSC_CPU_USER,
    BDSC_CPU_BGND,
    BDSC_CPU_STEP
  } bdsc_cpu_t;
endpackage

// ===== verilog/bdsc_sync3.sv
// Three-stage synchroniser with agreement filter for a pin input.
module bdsc_sync3 (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // Pin in, filtered level out
  input  wire logic pin_in,
  output logic      level_out
);
  logic s1_reg, s2_reg, s3_reg, lvl_reg;
  logic lvl_next;

  always_comb begin
    lvl_next = lvl_reg;
    if (s2_reg == s3_reg) begin
      lvl_next = s3_reg;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s1_reg  <= 1'b1;
      s2_reg  <= 1'b1;
      s3_reg  <= 1'b1;
      lvl_reg <= 1'b1;
    end else begin
      s1_reg  <= pin_in;
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      lvl_reg <= lvl_next;
    end
  end

  assign level_out = lvl_reg;
endmodule

// ===== verilog/bdsc_top.sv
// Serial link timing, tagging and stepping control for background debug.
module bdsc_top
  import bdsc_pkg::*;
#(
  parameter int TIMEOUT = bdsc_pkg::TIMEOUT_CYC
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // Serial pin, open drain: oe low means driving
  input  wire logic serial_in,
  output logic      serial_out,
  output logic      serial_oe_n,
  // Low byte strobe pin used as tag input
  input  wire logic low_strobe_in,
  input  wire logic low_strobe_enabled,
  input  wire logic external_bus_clock,
  // Command decode from the protocol engine
  input  wire logic cmd_complete,
  input  wire logic cmd_is_read,
  input  wire logic xfer_done,
  input  wire logic ack_enable_cmd,
  input  wire logic ack_disable_cmd,
  input  wire logic ack_pulse_sent,
  input  wire logic single_step_command,
  input  wire logic tag_and_go_command,
  input  wire logic clocks_restarted,
  // Processor side
  input  wire logic irq_pending,
  input  wire logic insn_retired,
  input  wire logic queue_load,
  input  wire logic queue_advance,
  // Status
  output logic      soft_reset,
  output logic      bit_valid,
  output logic      sync_seen,
  output logic      ack_enabled,
  output logic      tagging_active,
  output logic      background_debug_mode,
  output logic      run_user,
  output logic      take_irq_stack,
  output logic [1:0] tag_seen
);
  if (TIMEOUT < 2 || TIMEOUT > 1023) $error("TIMEOUT out of range");
  default clocking cb_sys @(posedge sys_clk); endclocking
  default disable iff (rst);

  logic pin_lvl, lo_lvl, clk_lvl;

  bdsc_sync3 u_pin (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .pin_in   (serial_in),
    .level_out(pin_lvl)
  );
  bdsc_sync3 u_lo (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .pin_in   (low_strobe_in),
    .level_out(lo_lvl)
  );
  bdsc_sync3 u_clk (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .pin_in   (external_bus_clock),
    .level_out(clk_lvl)
  );

  // Receive timing.
  bdsc_rx_t        rx_reg, rx_next;
  bdsc_rsp_t       rsp_reg, rsp_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic pin_d_reg, clk_d_reg;
  logic busy_reg, busy_next, hold_reg, hold_next;
  logic srst_reg, srst_next, bit_reg, bit_next, sync_reg, sync_next;
  logic ack_reg, ack_next;
  logic fall, rise, clk_fall, expire;

  assign fall     = pin_d_reg & ~pin_lvl;
  assign rise     = ~pin_d_reg & pin_lvl;
  assign clk_fall = clk_d_reg & ~clk_lvl;
  assign expire   = busy_reg & ~hold_reg &
                    (cnt_reg >= CNT_W'(TIMEOUT));

  always_comb begin
    rx_next   = rx_reg;
    cnt_next  = cnt_reg;
    busy_next = busy_reg;
    hold_next = hold_reg;
    srst_next = 1'b0;
    bit_next  = 1'b0;
    sync_next = 1'b0;
    ack_next  = ack_reg;
    if (cnt_reg != {CNT_W{1'b1}}) cnt_next = cnt_reg + 1'b1;
    // Our own sync answer would otherwise read back as a host bit.
    if (fall && !tagging_active && rsp_reg == BDSC_RSP_IDLE) begin
      cnt_next = '0;
      rx_next  = BDSC_LOW;
    end
    case (rx_reg)
      BDSC_LOW: begin
        if (rise) begin
          bit_next  = 1'b1;
          busy_next = 1'b1;
          rx_next   = BDSC_GAP;
        end else if (cnt_reg >= CNT_W'(SYNC_LOW_CYC)) begin
          sync_next = 1'b1;
          srst_next = 1'b1;
          busy_next = 1'b0;
          hold_next = 1'b0;
          rx_next   = BDSC_WAIT_HI;
        end
      end
      BDSC_WAIT_HI: begin
        if (rise) rx_next = BDSC_IDLE;
      end
      BDSC_GAP: begin
        if (expire) begin
          srst_next = 1'b1;
          busy_next = 1'b0;
          hold_next = 1'b0;
          rx_next   = BDSC_IDLE;
        end
      end
      default: ;
    endcase
    if (cmd_complete) begin
      busy_next = cmd_is_read;
      hold_next = cmd_is_read & ack_reg;
    end
    if (ack_pulse_sent && !tag_and_go_command) begin
      hold_next = 1'b0;
      cnt_next  = '0;
    end
    if (xfer_done) begin
      busy_next = 1'b0;
      hold_next = 1'b0;
    end
    if (ack_enable_cmd) ack_next = 1'b1;
    if (ack_disable_cmd) ack_next = 1'b0;
    if (clocks_restarted) begin
      srst_next = 1'b1;
      ack_next  = 1'b0;
      busy_next = 1'b0;
      hold_next = 1'b0;
      rx_next   = BDSC_IDLE;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rx_reg    <= BDSC_IDLE;
      cnt_reg   <= '0;
      pin_d_reg <= 1'b1;
      clk_d_reg <= 1'b1;
      busy_reg  <= 1'b0;
      hold_reg  <= 1'b0;
      srst_reg  <= 1'b0;
      bit_reg   <= 1'b0;
      sync_reg  <= 1'b0;
      ack_reg   <= 1'b0;
    end else begin
      rx_reg    <= rx_next;
      cnt_reg   <= cnt_next;
      pin_d_reg <= pin_lvl;
      clk_d_reg <= clk_lvl;
      busy_reg  <= busy_next;
      hold_reg  <= hold_next;
      srst_reg  <= srst_next;
      bit_reg   <= bit_next;
      sync_reg  <= sync_next;
      ack_reg   <= ack_next;
    end
  end

  // Sync response pulse; our own drive is ignored by the receiver state.
  logic [7:0]       rcnt_reg, rcnt_next;
  logic oe_n_reg, oe_n_next, out_reg, out_next;

  always_comb begin
    rsp_next  = rsp_reg;
    rcnt_next = rcnt_reg + 8'h01;
    oe_n_next = 1'b1;
    out_next  = 1'b1;
    case (rsp_reg)
      BDSC_RSP_IDLE: begin
        rcnt_next = 8'h00;
        if (rx_reg == BDSC_WAIT_HI && rise) rsp_next = BDSC_RSP_DELAY;
      end
      BDSC_RSP_DELAY: begin
        if (rcnt_reg == 8'(SYNC_DELAY_CYC - 1)) begin
          rcnt_next = 8'h00;
          rsp_next  = BDSC_RSP_LOW;
          oe_n_next = 1'b0;
          out_next  = 1'b0;
        end
      end
      BDSC_RSP_LOW: begin
        oe_n_next = 1'b0;
        out_next  = 1'b0;
        if (rcnt_reg == 8'(SYNC_RESP_CYC - 1)) begin
          rsp_next = BDSC_RSP_SPEED;
          out_next = 1'b1;
        end
      end
      BDSC_RSP_SPEED: rsp_next = BDSC_RSP_IDLE;
      default: rsp_next = BDSC_RSP_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rsp_reg  <= BDSC_RSP_IDLE;
      rcnt_reg <= 8'h00;
      oe_n_reg <= 1'b1;
      out_reg  <= 1'b1;
    end else begin
      rsp_reg  <= rsp_next;
      rcnt_reg <= rcnt_next;
      oe_n_reg <= oe_n_next;
      out_reg  <= out_next;
    end
  end

  // Tagging and stepping.
  bdsc_cpu_t cpu_reg, cpu_next;
  logic tag_on_reg, tag_on_next, irqs_reg, irqs_next, bgd_reg, run_reg;
  logic [1:0] tag_reg, tag_next;
  logic [1:0] q_reg [QUEUE_DEPTH];
  logic [1:0] q_next [QUEUE_DEPTH];

  always_comb begin
    cpu_next    = cpu_reg;
    tag_on_next = tag_on_reg;
    tag_next    = tag_reg;
    irqs_next   = 1'b0;
    q_next      = q_reg;
    if (tag_and_go_command && !tag_on_reg) begin
      tag_on_next = 1'b1;
      cpu_next    = BDSC_CPU_USER;
    end
    if (tag_on_reg && clk_fall) begin
      tag_next[1] = ~pin_lvl;
      tag_next[0] = ~lo_lvl & low_strobe_enabled;
    end
    if (queue_load) begin
      q_next[QUEUE_DEPTH-1] = tag_on_reg ? tag_next : 2'b00;
    end
    if (queue_advance) begin
      for (int i = 0; i < QUEUE_DEPTH - 1; i++) begin
        q_next[i] = q_reg[i+1];
      end
      if (!queue_load) q_next[QUEUE_DEPTH-1] = 2'b00;
    end
    case (cpu_reg)
      BDSC_CPU_USER: begin
        if (queue_advance && q_reg[0] != 2'b00) begin
          cpu_next    = BDSC_CPU_BGND;
          tag_on_next = 1'b0;
        end
      end
      BDSC_CPU_BGND: begin
        if (single_step_command) begin
          if (irq_pending) begin
            irqs_next = 1'b1;
          end else begin
            cpu_next = BDSC_CPU_STEP;
          end
        end
      end
      BDSC_CPU_STEP: begin
        if (insn_retired) cpu_next = BDSC_CPU_BGND;
      end
      default: cpu_next = BDSC_CPU_BGND;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cpu_reg    <= BDSC_CPU_USER;
      tag_on_reg <= 1'b0;
      tag_reg    <= 2'b00;
      irqs_reg   <= 1'b0;
      bgd_reg    <= 1'b0;
      run_reg    <= 1'b1;
      for (int i = 0; i < QUEUE_DEPTH; i++) q_reg[i] <= 2'b00;
    end else begin
      cpu_reg    <= cpu_next;
      tag_on_reg <= tag_on_next;
      tag_reg    <= tag_next;
      irqs_reg   <= irqs_next;
      bgd_reg    <= (cpu_next == BDSC_CPU_BGND);
      run_reg    <= (cpu_next != BDSC_CPU_BGND);
      q_reg      <= q_next;
    end
  end

  assign serial_out            = out_reg;
  assign serial_oe_n           = oe_n_reg;
  assign soft_reset            = srst_reg;
  assign bit_valid             = bit_reg;
  assign sync_seen             = sync_reg;
  assign ack_enabled           = ack_reg;
  assign tagging_active        = tag_on_reg;
  assign background_debug_mode = bgd_reg;
  assign run_user              = run_reg;
  assign take_irq_stack        = irqs_reg;
  assign tag_seen              = tag_reg;
  property p_ack_reset;
    clocks_restarted |=> !ack_enabled && soft_reset;
  endproperty
  a_ack_reset: assert property (p_ack_reset)
    else $error("restart did not clear handshake");
  property p_sync_low;
    $rose(~serial_oe_n) |-> (~serial_oe_n && !serial_out) [*8];
  endproperty
  a_sync_low: assert property (p_sync_low)
    else $error("sync answer too short");
  property p_tag_off;
    $rose(background_debug_mode) |-> !tagging_active;
  endproperty
  a_tag_off: assert property (p_tag_off)
    else $error("tagging stayed on in background");
  property p_speedup;
    !serial_oe_n && serial_out |=> serial_oe_n;
  endproperty
  a_speedup: assert property (p_speedup)
    else $error("speedup pulse longer than one cycle");
  property p_step_one;
    background_debug_mode && single_step_command && !irq_pending |=> run_user;
  endproperty
  a_step_one: assert property (p_step_one)
    else $error("single step did not leave background");
  property p_irq_stack;
    take_irq_stack |-> background_debug_mode;
  endproperty
  a_irq_stack: assert property (p_irq_stack)
    else $error("interrupt stacking ran user code");
endmodule
